// File: api_response_frame_builder.sv
// api response frame builder with apb registers and byte stream output
// Behaviour
// - legacy receive frames (type 80h) sent only when format setting is 2
// - sender 64-bit address in bytes 4..11, most significant first
// - byte 12 holds rssi magnitude of the negative dBm value
// - options bit 0 acknowledged, bit 1 broadcast
// - options bits 7:6 give delivery method 01, 10 or 11
// - command response frame type 88h for each command request with a nonzero frame id
// - byte 4 echoes frame id; id zero gives no response
// - bytes 5 and 6 carry the two command name characters
// - byte 7 status 0 ok, 1 error, 2 unknown, 3 bad parameter
// - queried value from byte 8 on; omitted when setting was written
// - transmit completion gives status frame type 89h
// - byte 4 of transmit status carries the request frame id
// - byte 5 is 00h on success, 01h when no ack came
`timescale 1ns/1ps
`default_nettype none
module api_response_frame_builder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire frame_builder_pkg::req_type req,
  output logic req_ready,
  input wire logic pay_we,
  input wire logic [5:0] pay_addr,
  input wire logic [7:0] pay_wdata,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  output logic irq
);

  frame_builder_pkg::phase_type phase_ff;
  frame_builder_pkg::phase_type nxt_phase;
  frame_builder_pkg::req_type req_ff;
  logic [7:0] pay_mem [frame_builder_pkg::PAY_DEPTH];
  logic [7:0] ctrl_ff;
  logic [3:0] status_ff;
  logic [3:0] mask_ff;
  logic [15:0] count_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic req_ready_ff;
  logic out_valid_ff;
  logic [7:0] out_data_ff;
  logic irq_ff;
  logic [6:0] idx_ff;
  logic [6:0] frame_len;
  logic [7:0] body_byte;
  logic [7:0] nxt_out_data;
  logic [7:0] csum;
  logic [3:0] set_bits;
  logic take;
  logic drop;
  logic adv;
  logic apb_acc;
  logic apb_wr;
  logic [2:0] byte_sel;
  logic [6:0] pay_idx;

  assign take = req_valid && req_ready_ff;
  assign adv = !out_valid_ff || out_ready;
  assign apb_acc = psel && penable && !pready_ff;
  assign apb_wr = psel && penable && pready_ff && pwrite;

  // requests that yield no frame at all
  always_comb begin
    drop = 1'b0;
    if (req.kind == frame_builder_pkg::KIND_RX) begin
      drop = ctrl_ff != frame_builder_pkg::FMT_LEGACY;
    end else if (req.kind == frame_builder_pkg::KIND_CMD) begin
      drop = req.frame_id == 8'h00;
    end else if (req.kind != frame_builder_pkg::KIND_TX) begin
      drop = 1'b1;
    end
  end

  // body length from type byte to last data byte
  always_comb begin
    frame_len = frame_builder_pkg::TX_LEN;
    if (req_ff.kind == frame_builder_pkg::KIND_RX) begin
      frame_len = frame_builder_pkg::RX_HDR_LEN + req_ff.data_len;
    end else if (req_ff.kind == frame_builder_pkg::KIND_CMD) begin
      frame_len = frame_builder_pkg::CMD_HDR_LEN
        + (req_ff.is_write ? 7'd0 : req_ff.data_len);
    end
  end

  // body byte at the current index
  assign byte_sel = 3'(frame_builder_pkg::ADDR_LAST_IDX[3:0] - idx_ff[3:0]);
  assign pay_idx = idx_ff - ((req_ff.kind == frame_builder_pkg::KIND_RX) ?
    frame_builder_pkg::RX_HDR_LEN : frame_builder_pkg::CMD_HDR_LEN);
  always_comb begin
    body_byte = pay_mem[pay_idx[5:0]];
    if (req_ff.kind == frame_builder_pkg::KIND_RX) begin
      if (idx_ff == 7'd0) begin
        body_byte = frame_builder_pkg::RX_TYPE;
      end else if (idx_ff <= frame_builder_pkg::ADDR_LAST_IDX) begin
        body_byte = req_ff.src_addr[{byte_sel, 3'b000} +: 8];
      end else if (idx_ff == frame_builder_pkg::RSSI_IDX) begin
        body_byte = req_ff.rssi;
      end else if (idx_ff == frame_builder_pkg::OPT_IDX) begin
        body_byte = {req_ff.method, 4'h0, req_ff.bcast, req_ff.acked};
      end
    end else if (req_ff.kind == frame_builder_pkg::KIND_CMD) begin
      if (idx_ff == 7'd0) begin
        body_byte = frame_builder_pkg::CMD_TYPE;
      end else if (idx_ff == frame_builder_pkg::ID_IDX) begin
        body_byte = req_ff.frame_id;
      end else if (idx_ff == frame_builder_pkg::NAME_HI_IDX) begin
        body_byte = req_ff.cmd_name[15:8];
      end else if (idx_ff == frame_builder_pkg::NAME_LO_IDX) begin
        body_byte = req_ff.cmd_name[7:0];
      end else if (idx_ff == frame_builder_pkg::CSTAT_IDX) begin
        body_byte = req_ff.status;
      end
    end else begin
      if (idx_ff == 7'd0) begin
        body_byte = frame_builder_pkg::TX_TYPE;
      end else if (idx_ff == frame_builder_pkg::ID_IDX) begin
        body_byte = req_ff.frame_id;
      end else begin
        body_byte = {7'h00, req_ff.status[0]};
      end
    end
  end

  // checksum over type byte through last data byte
  frame_checksum u_csum (
    .clk(clk),
    .rst_n(rst_n),
    .clear(phase_ff == frame_builder_pkg::PH_LEN_LO),
    .add(adv && phase_ff == frame_builder_pkg::PH_BODY),
    .data(body_byte),
    .csum(csum)
  );

  // frame sequencer
  always_comb begin
    nxt_phase = phase_ff;
    nxt_out_data = out_data_ff;
    unique case (phase_ff)
      frame_builder_pkg::PH_IDLE: begin
        if (take && !drop) begin
          nxt_phase = frame_builder_pkg::PH_DELIM;
        end
      end
      frame_builder_pkg::PH_DELIM: begin
        nxt_out_data = frame_builder_pkg::DELIM_BYTE;
        nxt_phase = frame_builder_pkg::PH_LEN_HI;
      end
      frame_builder_pkg::PH_LEN_HI: begin
        nxt_out_data = 8'h00;
        nxt_phase = frame_builder_pkg::PH_LEN_LO;
      end
      frame_builder_pkg::PH_LEN_LO: begin
        nxt_out_data = {1'b0, frame_len};
        nxt_phase = frame_builder_pkg::PH_BODY;
      end
      frame_builder_pkg::PH_BODY: begin
        nxt_out_data = body_byte;
        if (idx_ff == frame_len - 7'd1) begin
          nxt_phase = frame_builder_pkg::PH_CSUM;
        end
      end
      frame_builder_pkg::PH_CSUM: begin
        nxt_out_data = csum;
        nxt_phase = frame_builder_pkg::PH_IDLE;
      end
    endcase
  end

  // phase and byte index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= frame_builder_pkg::PH_IDLE;
      idx_ff <= 7'd0;
    end else if (adv) begin
      phase_ff <= nxt_phase;
      if (phase_ff == frame_builder_pkg::PH_BODY) begin
        idx_ff <= idx_ff + 7'd1;
      end else begin
        idx_ff <= 7'd0;
      end
    end
  end

  // output byte stream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= 8'h00;
    end else if (adv) begin
      out_valid_ff <= phase_ff != frame_builder_pkg::PH_IDLE;
      out_data_ff <= nxt_out_data;
    end
  end

  // request capture; one request per frame; a dropped request leaves ready low for one cycle only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= '0;
      req_ready_ff <= 1'b0;
    end else begin
      if (take) begin
        req_ff <= req;
      end
      req_ready_ff <= !take && !out_valid_ff
        && nxt_phase == frame_builder_pkg::PH_IDLE
        && phase_ff == frame_builder_pkg::PH_IDLE;
    end
  end

  // payload buffer, written by the firmware side
  always_ff @(posedge clk) begin
    if (pay_we) begin
      pay_mem[pay_addr] <= pay_wdata;
    end
  end

  // frame events
  always_comb begin
    set_bits = 4'h0;
    if (adv && phase_ff == frame_builder_pkg::PH_CSUM) begin
      set_bits[req_ff.kind] = 1'b1;
    end
    set_bits[frame_builder_pkg::DROP_BIT] = take && drop;
  end

  // apb answer: one wait cycle in the access phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= apb_acc;
      pslverr_ff <= apb_acc && paddr != frame_builder_pkg::CTRL_OFS
        && paddr != frame_builder_pkg::STATUS_OFS
        && paddr != frame_builder_pkg::MASK_OFS
        && paddr != frame_builder_pkg::COUNT_OFS;
      prdata_ff <= 32'h0000_0000;
      if (apb_acc && !pwrite) begin
        unique case (paddr)
          frame_builder_pkg::CTRL_OFS: prdata_ff <= {24'h0, ctrl_ff};
          frame_builder_pkg::STATUS_OFS: prdata_ff <= {23'h0,
            phase_ff != frame_builder_pkg::PH_IDLE, 4'h0, status_ff};
          frame_builder_pkg::MASK_OFS: prdata_ff <= {28'h0, mask_ff};
          frame_builder_pkg::COUNT_OFS: prdata_ff <= {16'h0, count_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control, mask and frame counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= frame_builder_pkg::CTRL_RST;
      mask_ff <= frame_builder_pkg::MASK_RST;
      count_ff <= frame_builder_pkg::COUNT_RST;
    end else begin
      if (apb_wr && paddr == frame_builder_pkg::CTRL_OFS) begin
        ctrl_ff <= pwdata[7:0];
      end
      if (apb_wr && paddr == frame_builder_pkg::MASK_OFS) begin
        mask_ff <= pwdata[3:0];
      end
      if (adv && phase_ff == frame_builder_pkg::PH_CSUM) begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= frame_builder_pkg::STATUS_RST;
    end else if (apb_wr && paddr == frame_builder_pkg::STATUS_OFS) begin
      status_ff <= (status_ff & ~pwdata[3:0]) | set_bits;
    end else begin
      status_ff <= status_ff | set_bits;
    end
  end

  // interrupt level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign req_ready = req_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_RX_GATE: assert property (
    take && req.kind == frame_builder_pkg::KIND_RX
    && ctrl_ff != frame_builder_pkg::FMT_LEGACY
    |=> phase_ff == frame_builder_pkg::PH_IDLE && !out_valid_ff)
    else $error("rx frame sent outside legacy format");
  AST_RX_TYPE: assert property (
    adv && phase_ff == frame_builder_pkg::PH_BODY && idx_ff == 7'd0
    && req_ff.kind == frame_builder_pkg::KIND_RX |=> out_data_ff == 8'h80)
    else $error("wrong legacy receive type byte");
  AST_ADDR_MSB: assert property (
    adv && phase_ff == frame_builder_pkg::PH_BODY && idx_ff == 7'd1
    && req_ff.kind == frame_builder_pkg::KIND_RX
    |=> out_data_ff == req_ff.src_addr[63:56])
    else $error("address not most significant first");
  AST_RSSI: assert property (
    adv && phase_ff == frame_builder_pkg::PH_BODY && idx_ff == 7'd9
    && req_ff.kind == frame_builder_pkg::KIND_RX |=> out_data_ff == req_ff.rssi)
    else $error("rssi byte wrong");
  AST_OPTIONS: assert property (
    adv && phase_ff == frame_builder_pkg::PH_BODY && idx_ff == 7'd10
    && req_ff.kind == frame_builder_pkg::KIND_RX
    |=> out_data_ff[1:0] == {req_ff.bcast, req_ff.acked}
    && out_data_ff[7:6] == req_ff.method)
    else $error("options byte wrong");
  AST_CMD_ZERO: assert property (
    take && req.kind == frame_builder_pkg::KIND_CMD && req.frame_id == 8'h00
    |=> phase_ff == frame_builder_pkg::PH_IDLE)
    else $error("response sent for frame id zero");
  AST_CMD_TYPE: assert property (
    adv && phase_ff == frame_builder_pkg::PH_BODY && idx_ff == 7'd0
    && req_ff.kind == frame_builder_pkg::KIND_CMD |=> out_data_ff == 8'h88)
    else $error("wrong command response type byte");
  AST_CMD_NAME: assert property (
    adv && phase_ff == frame_builder_pkg::PH_BODY && idx_ff == 7'd3
    && req_ff.kind == frame_builder_pkg::KIND_CMD
    |=> out_data_ff == req_ff.cmd_name[7:0]
    && $past(out_data_ff) == req_ff.cmd_name[15:8])
    else $error("command name bytes wrong");
  AST_CMD_WRITE_LEN: assert property (
    adv && phase_ff == frame_builder_pkg::PH_LEN_LO
    && req_ff.kind == frame_builder_pkg::KIND_CMD && req_ff.is_write
    |=> out_data_ff == 8'h05)
    else $error("write response carries data");
  AST_TX_STATUS: assert property (
    adv && phase_ff == frame_builder_pkg::PH_BODY && idx_ff == 7'd2
    && req_ff.kind == frame_builder_pkg::KIND_TX
    |=> out_data_ff == {7'h00, req_ff.status[0]}
    && $past(out_data_ff) == req_ff.frame_id)
    else $error("transmit status bytes wrong");
  AST_HEAD: assert property (
    adv && phase_ff == frame_builder_pkg::PH_DELIM
    |=> out_valid_ff && out_data_ff == 8'h7e
    ##1 (!$past(out_ready) || out_data_ff == 8'h00))
    else $error("frame head wrong");

endmodule : api_response_frame_builder
`default_nettype wire

// File: frame_builder_pkg.sv
// shared constants, types and register map of the response frame builder
package frame_builder_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;

  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // status and mask bit positions
  localparam int RX_SENT_BIT = 0;
  localparam int CMD_SENT_BIT = 1;
  localparam int TX_SENT_BIT = 2;
  localparam int DROP_BIT = 3;
  localparam int BUSY_BIT = 8;

  // output format value that turns on legacy receive frames
  localparam logic [7:0] FMT_LEGACY = 8'h02;

  // frame bytes
  localparam logic [7:0] DELIM_BYTE = 8'h7e;
  localparam logic [7:0] RX_TYPE = 8'h80;
  localparam logic [7:0] CMD_TYPE = 8'h88;
  localparam logic [7:0] TX_TYPE = 8'h89;
  localparam logic [7:0] CSUM_BASE = 8'hff;

  // body byte positions counted from the type byte (frame offset 3)
  localparam logic [6:0] ADDR_LAST_IDX = 7'd8;
  localparam logic [6:0] RSSI_IDX = 7'd9;
  localparam logic [6:0] OPT_IDX = 7'd10;
  localparam logic [6:0] RX_HDR_LEN = 7'd11;
  localparam logic [6:0] ID_IDX = 7'd1;
  localparam logic [6:0] NAME_HI_IDX = 7'd2;
  localparam logic [6:0] NAME_LO_IDX = 7'd3;
  localparam logic [6:0] CSTAT_IDX = 7'd4;
  localparam logic [6:0] CMD_HDR_LEN = 7'd5;
  localparam logic [6:0] TSTAT_IDX = 7'd2;
  localparam logic [6:0] TX_LEN = 7'd3;

  // command status codes
  localparam logic [7:0] CSTAT_OK = 8'h00;
  localparam logic [7:0] CSTAT_ERROR = 8'h01;
  localparam logic [7:0] CSTAT_BAD_CMD = 8'h02;
  localparam logic [7:0] CSTAT_BAD_PARAM = 8'h03;

  // delivery method codes in the options byte
  localparam logic [1:0] METH_PTMP = 2'b01;
  localparam logic [1:0] METH_REPEATER = 2'b10;
  localparam logic [1:0] METH_MESH = 2'b11;

  // payload buffer
  localparam int PAY_DEPTH = 64;
  localparam int PAY_AW = 6;

  // kinds of request
  localparam logic [1:0] KIND_RX = 2'd0;
  localparam logic [1:0] KIND_CMD = 2'd1;
  localparam logic [1:0] KIND_TX = 2'd2;

  // one frame request from the module firmware side
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] frame_id;
    logic [63:0] src_addr;
    logic [7:0] rssi;
    logic acked;
    logic bcast;
    logic [1:0] method;
    logic [15:0] cmd_name;
    logic [7:0] status;
    logic is_write;
    logic [6:0] data_len;
  } req_type;

  typedef enum logic [5:0] {
    PH_IDLE = 6'b000001,
    PH_DELIM = 6'b000010,
    PH_LEN_HI = 6'b000100,
    PH_LEN_LO = 6'b001000,
    PH_BODY = 6'b010000,
    PH_CSUM = 6'b100000
  } phase_type;

endpackage : frame_builder_pkg

// File: frame_checksum.sv
// running checksum over the body bytes of one frame
`timescale 1ns/1ps
`default_nettype none
module frame_checksum (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic add,
  input wire logic [7:0] data,
  output logic [7:0] csum
);

  logic [7:0] sum_ff;

  // low eight bits of the byte sum
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_ff <= 8'h00;
    end else if (clear) begin
      sum_ff <= 8'h00;
    end else if (add) begin
      sum_ff <= sum_ff + data;
    end
  end

  // final byte sent after the body
  assign csum = frame_builder_pkg::CSUM_BASE - sum_ff;

endmodule : frame_checksum
`default_nettype wire

// File: host_sink.sv
// host side byte sink of the frame stream, with optional back-pressure
`timescale 1ns/1ps
`default_nettype none
module host_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready
);
  logic [7:0] got [$];
  logic [1:0] pace_ff;

  // free running pace counter for the stall pattern
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_ff <= 2'd0;
    end else begin
      pace_ff <= pace_ff + 2'd1;
    end
  end

  // stalls two of every four cycles when slow
  assign out_ready = !slow || pace_ff[1];

  // raw byte log; only option bits 0,1,6,7 carry meaning here
  always @(posedge clk) begin
    if (rst_n && out_valid && out_ready) begin
      got.push_back(out_data);
    end
  end
endmodule : host_sink
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the response frame builder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic req_valid, req_ready, pay_we, out_valid, out_ready, slow;
  frame_builder_pkg::req_type req;
  logic [5:0] pay_addr;
  logic [7:0] pay_wdata, out_data;
  logic [7:0] body [$];
  int miscompares, checks_done, sent;

  api_response_frame_builder DUT (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .pay_we(pay_we),
    .pay_addr(pay_addr), .pay_wdata(pay_wdata), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .irq(irq)
  );

  host_sink host (
    .clk(clk), .rst_n(rst_n), .slow(slow), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready)
  );

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task complete_run;
    $display("miscompares %0d checks_done %0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] v, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, a, d, v, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] v;
    logic e;
    apb(1'b0, a, 32'h0, v, e);
    chk(v, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd

  task load(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      pay_we <= 1'b1;
      pay_addr <= 6'(i);
      pay_wdata <= base + 8'(i);
    end
    @(posedge clk);
    pay_we <= 1'b0;
  endtask : load

  // request held until taken with req_ready high
  task send(input frame_builder_pkg::req_type r);
    @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask : send

  // wraps the expected body and compares the whole frame
  task expect_frame;
    logic [7:0] sum;
    int k;
    sum = 8'h00;
    foreach (body[i])
      sum += body[i];
    k = body.size();
    body.push_front(8'(k));
    body.push_front(8'(k >> 8));
    body.push_front(frame_builder_pkg::DELIM_BYTE);
    body.push_back(frame_builder_pkg::CSUM_BASE - sum);
    k = 0;
    while (host.got.size() < body.size() && k < 3000) begin
      @(posedge clk);
      k++;
    end
    repeat (3) @(posedge clk);
    chk(32'(host.got.size()), 32'(body.size()));
    foreach (body[i])
      chk(32'(host.got[i]), 32'(body[i]));
    host.got.delete();
    body.delete();
    sent++;
  endtask : expect_frame

  task expect_drop;
    repeat (10) @(posedge clk);
    chk(32'(host.got.size()), 32'h0);
  endtask : expect_drop

  // watchdog
  initial begin
    #500000;
    miscompares++;
    complete_run();
  end

  // main sequence
  initial begin
    frame_builder_pkg::req_type r;
    int n;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_valid = 1'b0;
    req = '0;
    pay_we = 1'b0;
    pay_addr = 6'h00;
    pay_wdata = 8'h00;
    slow = 1'b0;
    miscompares = 0;
    checks_done = 0;
    sent = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped place
    rd(frame_builder_pkg::CTRL_OFS, 32'h0, 1'b0);
    rd(frame_builder_pkg::STATUS_OFS, 32'h0, 1'b0);
    rd(frame_builder_pkg::MASK_OFS, 32'h0, 1'b0);
    rd(frame_builder_pkg::COUNT_OFS, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    // rx request before legacy format is dropped
    r = '0;
    r.kind = frame_builder_pkg::KIND_RX;
    send(r);
    expect_drop();
    rd(frame_builder_pkg::STATUS_OFS, 32'h8, 1'b0);
    chk({31'h0, irq}, 32'h0);
    wr(frame_builder_pkg::MASK_OFS, 32'h8);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(frame_builder_pkg::STATUS_OFS, 32'h8);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(frame_builder_pkg::CTRL_OFS, 32'h2);
    rd(frame_builder_pkg::CTRL_OFS, 32'h2, 1'b0);
    // rx frames, each delivery method, payload 6, 0 and 64 bytes
    for (int m = 1; m < 4; m++) begin
      n = (m == 1) ? 6 : ((m == 2) ? 0 : 64);
      slow <= (m == 3);
      load(n, 8'(16 * m));
      r = '0;
      r.kind = frame_builder_pkg::KIND_RX;
      r.src_addr = 64'h0011223344556677 + 64'(m);
      r.rssi = 8'd40;
      r.acked = m[0];
      r.bcast = m[1];
      r.method = 2'(m);
      r.data_len = 7'(n);
      send(r);
      // busy flag seen while the slow frame is still going out
      if (m == 3) rd(frame_builder_pkg::STATUS_OFS, 32'h101, 1'b0);
      body.push_back(frame_builder_pkg::RX_TYPE);
      for (int i = 7; i >= 0; i--)
        body.push_back(r.src_addr[8*i +: 8]);
      body.push_back(8'd40);
      body.push_back({2'(m), 4'h0, m[1], m[0]});
      for (int i = 0; i < n; i++)
        body.push_back(8'(16 * m + i));
      expect_frame();
    end
    slow <= 1'b0;
    // command responses, every status code, query and write
    for (int s = 0; s < 4; s++) begin
      load(2, 8'ha0);
      r = '0;
      r.kind = frame_builder_pkg::KIND_CMD;
      r.frame_id = 8'(s + 1);
      r.cmd_name = 16'h4244;
      r.status = 8'(s);
      r.is_write = s[0];
      r.data_len = 7'd2;
      send(r);
      body = '{frame_builder_pkg::CMD_TYPE, 8'(s + 1), 8'h42, 8'h44};
      body.push_back(8'(s));
      if (!s[0]) begin
        body.push_back(8'ha0);
        body.push_back(8'ha1);
      end
      expect_frame();
    end
    // command with frame id zero gets no answer
    r.frame_id = 8'h00;
    send(r);
    expect_drop();
    // an undefined request kind is refused as well
    r.kind = 2'd3;
    send(r);
    expect_drop();
    // transmit status, success and no acknowledgement
    for (int t = 0; t < 2; t++) begin
      r = '0;
      r.kind = frame_builder_pkg::KIND_TX;
      r.frame_id = 8'h55 + 8'(t);
      r.status = 8'(t);
      send(r);
      body = '{frame_builder_pkg::TX_TYPE, 8'h55 + 8'(t), 8'(t)};
      expect_frame();
    end
    rd(frame_builder_pkg::COUNT_OFS, 32'(sent), 1'b0);
    rd(frame_builder_pkg::STATUS_OFS, 32'hf, 1'b0);
    chk({31'h0, irq}, 32'h1);
    wr(frame_builder_pkg::STATUS_OFS, 32'hf);
    rd(frame_builder_pkg::STATUS_OFS, 32'h0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
